// File: core/irc_pkg.sv
// Shared constants, register map and carrier types of the infrared codec and mode mux
package irc_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 50;
   // Oversample clock counts as stopped after this long without an edge
   localparam int STATIC_TIME_NS = 20000;
   localparam int STATIC_CYC_INT = (STATIC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [8:0] STATIC_CYC = 9'(STATIC_CYC_INT);
   localparam logic [4:0] TICKS_PER_BIT = 5'h10;
   localparam logic [4:0] TX_PULSE_TICKS = 5'h03;
   // LED is lit while the bit counter is above this value
   localparam logic [4:0] TX_ON_ABOVE = 5'h0d;
   localparam logic [2:0] LAST_BIT = 3'h7;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_TXDATA = 4'h8;
   localparam int CTRL_SW_TX_BIT = 0;
   localparam int CTRL_BYPASS_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam int ST_CODEC_BIT = 0;
   localparam int ST_ROUTE_BIT = 1;
   localparam int ST_ACT_BIT = 2;
   localparam int ST_EMPTY_BIT = 3;
   localparam int ST_FULL_BIT = 4;
   localparam int ST_BUSY_BIT = 5;
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 8;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [0:0] {
      SER_IDLE = 1'b0,
      SER_SHIFT = 1'b1
   } ser_state_t;

   typedef struct packed {
      logic oversample_clock;
      logic photodiode_input;
      logic shared_tx_input;
      logic wired_tx_first_input;
      logic wired_rx_first_input;
      logic wired_rx_second_input;
      logic infrared_route_select;
      logic wired_shutdown_n;
      logic optical_shutdown_n;
      logic optical_tx_input;
      logic separate_variant;
   } pins_in_t;

   typedef struct packed {
      logic out;
      logic oe;
   } pin_drive_t;

endpackage

// File: core/ir_pulse_codec_mode_mux.sv
// Infrared pulse codec, infrared/wired routing, activity detector and Avalon register slave
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.

// ****************************************
// Pin synchroniser
// ****************************************
module pin_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] held_reg;
   logic [W-1:0] agree;

   // A one-cycle glitch leaves stages two and three apart, so the last agreed value holds
   always_comb begin
      agree = ~(s2_reg ^ s3_reg);
      q = (s3_reg & agree) | (held_reg & ~agree);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         held_reg <= '0;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         held_reg <= q;
      end
   end
endmodule

// ****************************************
// Transmit word FIFO
// ****************************************
module fifo_buf #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0] wr_reg;
   logic [AW:0] rd_reg;
   logic [AW:0] wr_next;
   logic [AW:0] rd_next;
   logic push;
   logic pop;

   always_comb begin
      in_ready = (wr_reg - rd_reg) != (AW + 1)'(DEPTH);
      out_valid = wr_reg != rd_reg;
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      wr_next = push ? wr_reg + 1'b1 : wr_reg;
      rd_next = pop ? rd_reg + 1'b1 : rd_reg;
      out_data = mem_reg[rd_reg[AW-1:0]];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
      end
   end

   // Storage carries no reset; only pointers decide what is valid
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_reg[AW-1:0]] <= in_data;
      end
   end
endmodule

// Function
// - Codec runs only with a running 16x clock
// - Stopped 16x clock bypasses the codec
// - Received light pulse stretched to one bit
// - Low transmit bit becomes three-tick light pulse
// - Bypass: receive output low per light pulse
// - Bypass: LED follows transmit input high
// - Route low, shared variant: shared pins serve infrared
// - Route low, shared variant: pumps off, wired outputs floating
// - Route high, shared variant: wired path, LED forced off
// - Wired outputs drive only out of shutdown, with route high or separate variant
// - Detector watches the deselected receive path
// - Any edge drives activity flag low
// - Route transition clears activity flag
// - Separate variant uses dedicated optical pins
// - Optical shutdown disables receiver, output high
// - Wired receivers always on and inverting
module ir_pulse_codec_mode_mux (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Avalon-MM slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Pins from outside
   input wire irc_pkg::pins_in_t pins_in,
   // Optical side
   output logic led_sink_output,
   output logic led_sink_oe,
   output logic optical_rx_output,
   // Wired side
   output logic wired_tx_first_output,
   output logic wired_tx_first_oe,
   output logic wired_tx_second_output,
   output logic wired_tx_second_oe,
   output logic charge_pump_en,
   output logic wired_rx_first_output,
   // Shared and activity
   output logic shared_rx_output,
   output logic idle_line_activity_n
);
   // ****************************************
   // Input synchronisation
   // ****************************************
   irc_pkg::pins_in_t p;
   logic [$bits(irc_pkg::pins_in_t)-1:0] p_vec;

   pin_sync #(.W($bits(irc_pkg::pins_in_t))) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d(pins_in),
      .q(p_vec)
   );
   assign p = irc_pkg::pins_in_t'(p_vec);

   // ****************************************
   // State
   // ****************************************
   logic ovs_d_reg, ovs_d_next;
   logic [8:0] static_cnt_reg, static_cnt_next;
   logic codec_active_reg, codec_active_next;
   logic light_d_reg, light_d_next;
   logic [4:0] rx_cnt_reg, rx_cnt_next;
   logic [4:0] tx_cnt_reg, tx_cnt_next;
   logic ir_rx_reg, ir_rx_next;
   logic mon_d_reg, mon_d_next;
   logic route_d_reg, route_d_next;
   logic [1:0] ctrl_reg, ctrl_next;
   irc_pkg::ser_state_t ser_state_reg, ser_state_next;
   logic [7:0] ser_sh_reg, ser_sh_next;
   logic [2:0] ser_bit_reg, ser_bit_next;
   logic [4:0] ser_tick_reg, ser_tick_next;
   logic [31:0] readdata_next;
   logic waitrequest_next;
   irc_pkg::pin_drive_t led_next, tx1_next, tx2_next;
   logic opt_rx_next, pump_next, rx1_next, shared_rx_next, act_n_next;

   logic tick, light, light_rise, tx_src, shared_eff, ir_en, drive_en;
   logic monitored, route_chg, edge_seen, req, accept;
   logic fifo_in_ready, fifo_out_valid, fifo_out_ready, fifo_push;
   logic [7:0] fifo_out_data;

   fifo_buf #(.WIDTH(irc_pkg::FIFO_WIDTH), .DEPTH(irc_pkg::FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(fifo_push),
      .in_ready(fifo_in_ready),
      .in_data(writedata[7:0]),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      tick = p.oversample_clock && !ovs_d_reg;
      ovs_d_next = p.oversample_clock;
      if (p.oversample_clock != ovs_d_reg) begin
         static_cnt_next = '0;
      end else if (static_cnt_reg != irc_pkg::STATIC_CYC) begin
         static_cnt_next = static_cnt_reg + 9'h001;
      end else begin
         static_cnt_next = static_cnt_reg;
      end
      codec_active_next = (static_cnt_reg != irc_pkg::STATIC_CYC) &&
                          !ctrl_reg[irc_pkg::CTRL_BYPASS_BIT];

      light = p.photodiode_input && p.optical_shutdown_n;
      light_d_next = light;
      light_rise = light && !light_d_reg;

      if (!codec_active_reg || !p.optical_shutdown_n) begin
         rx_cnt_next = '0;
      end else if (light_rise) begin
         rx_cnt_next = irc_pkg::TICKS_PER_BIT;
      end else if (tick && rx_cnt_reg != 5'h00) begin
         rx_cnt_next = rx_cnt_reg - 5'h01;
      end else begin
         rx_cnt_next = rx_cnt_reg;
      end
      ir_rx_next = codec_active_reg ? (rx_cnt_next == 5'h00) : !light;

      // Serializer replaces the shared transmit pin while enabled
      shared_eff = ctrl_reg[irc_pkg::CTRL_SW_TX_BIT] ?
                   (ser_state_reg != irc_pkg::SER_SHIFT || ser_sh_reg[0]) :
                   p.shared_tx_input;
      // dedicated optical pins in separate variant
      tx_src = p.separate_variant ? p.optical_tx_input : shared_eff;
      // LED disabled when routed to wired in the shared variant
      ir_en = p.separate_variant || !p.infrared_route_select;

      if (!codec_active_reg) begin
         tx_cnt_next = '0;
      end else if (tick && tx_cnt_reg <= 5'h01 && !tx_src) begin
         tx_cnt_next = irc_pkg::TICKS_PER_BIT;
      end else if (tick && tx_cnt_reg != 5'h00) begin
         tx_cnt_next = tx_cnt_reg - 5'h01;
      end else begin
         tx_cnt_next = tx_cnt_reg;
      end
      led_next.out = 1'b0;
      led_next.oe = ir_en && (codec_active_reg ? (tx_cnt_reg > irc_pkg::TX_ON_ABOVE) : tx_src);
      opt_rx_next = ir_rx_next;

      drive_en = p.wired_shutdown_n && (p.separate_variant || p.infrared_route_select);
      pump_next = drive_en;
      tx1_next.out = !p.wired_tx_first_input;
      tx1_next.oe = drive_en;
      tx2_next.out = p.separate_variant ? !p.shared_tx_input : !shared_eff;
      tx2_next.oe = drive_en;
      rx1_next = !p.wired_rx_first_input;
      shared_rx_next = ir_en && !p.separate_variant ? ir_rx_next : !p.wired_rx_second_input;

      monitored = p.infrared_route_select ? ir_rx_next : !p.wired_rx_second_input;
      mon_d_next = monitored;
      route_d_next = p.infrared_route_select;
      route_chg = p.infrared_route_select != route_d_reg;
      // Source just switched, so a difference here is not a line edge
      edge_seen = (monitored != mon_d_reg) && !route_chg;
      if (edge_seen) begin
         act_n_next = 1'b0;
      end else if (route_chg) begin
         act_n_next = 1'b1;
      end else begin
         act_n_next = idle_line_activity_n;
      end

      // Register slave: answer one cycle after the request appears; a TXDATA write into a full FIFO waits for room
      req = read || write;
      accept = req && !waitrequest;
      fifo_push = accept && write && address == irc_pkg::ADDR_TXDATA;
      waitrequest_next = !(req && waitrequest &&
                           !(write && address == irc_pkg::ADDR_TXDATA && !fifo_in_ready));
      ctrl_next = ctrl_reg;
      if (accept && write && address == irc_pkg::ADDR_CTRL && byteenable[0]) begin
         ctrl_next = writedata[1:0];
      end
      readdata_next = '0;
      if (read && waitrequest) begin
         unique case (address)
            irc_pkg::ADDR_CTRL: readdata_next[1:0] = ctrl_reg;
            irc_pkg::ADDR_STATUS: begin
               readdata_next[irc_pkg::ST_CODEC_BIT] = codec_active_reg;
               readdata_next[irc_pkg::ST_ROUTE_BIT] = p.infrared_route_select;
               readdata_next[irc_pkg::ST_ACT_BIT] = idle_line_activity_n;
               readdata_next[irc_pkg::ST_EMPTY_BIT] = !fifo_out_valid;
               readdata_next[irc_pkg::ST_FULL_BIT] = !fifo_in_ready;
               readdata_next[irc_pkg::ST_BUSY_BIT] = ser_state_reg == irc_pkg::SER_SHIFT;
            end
            default: readdata_next = '0;
         endcase
      end

      // Serializer: one word, LSB first, sixteen ticks a bit
      ser_state_next = ser_state_reg;
      ser_sh_next = ser_sh_reg;
      ser_bit_next = ser_bit_reg;
      ser_tick_next = ser_tick_reg;
      fifo_out_ready = 1'b0;
      unique case (ser_state_reg)
         irc_pkg::SER_IDLE: begin
            fifo_out_ready = ctrl_reg[irc_pkg::CTRL_SW_TX_BIT];
            if (fifo_out_ready && fifo_out_valid) begin
               ser_state_next = irc_pkg::SER_SHIFT;
               ser_sh_next = fifo_out_data;
               ser_bit_next = irc_pkg::LAST_BIT;
               ser_tick_next = irc_pkg::TICKS_PER_BIT;
            end
         end
         irc_pkg::SER_SHIFT: begin
            if (tick) begin
               if (ser_tick_reg != 5'h01) begin
                  ser_tick_next = ser_tick_reg - 5'h01;
               end else if (ser_bit_reg == 3'h0) begin
                  ser_state_next = irc_pkg::SER_IDLE;
               end else begin
                  ser_sh_next = {1'b1, ser_sh_reg[7:1]};
                  ser_bit_next = ser_bit_reg - 3'h1;
                  ser_tick_next = irc_pkg::TICKS_PER_BIT;
               end
            end
         end
      endcase
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ovs_d_reg <= 1'b0;
         static_cnt_reg <= irc_pkg::STATIC_CYC;
         codec_active_reg <= 1'b0;
         light_d_reg <= 1'b0;
         rx_cnt_reg <= '0;
         tx_cnt_reg <= '0;
         ir_rx_reg <= 1'b1;
         mon_d_reg <= 1'b1;
         route_d_reg <= 1'b0;
         ctrl_reg <= irc_pkg::CTRL_RESET;
         ser_state_reg <= irc_pkg::SER_IDLE;
         ser_sh_reg <= '0;
         ser_bit_reg <= '0;
         ser_tick_reg <= '0;
         readdata <= '0;
         waitrequest <= 1'b1;
         led_sink_output <= 1'b0;
         led_sink_oe <= 1'b0;
         optical_rx_output <= 1'b1;
         wired_tx_first_output <= 1'b0;
         wired_tx_first_oe <= 1'b0;
         wired_tx_second_output <= 1'b0;
         wired_tx_second_oe <= 1'b0;
         charge_pump_en <= 1'b0;
         wired_rx_first_output <= 1'b1;
         shared_rx_output <= 1'b1;
         idle_line_activity_n <= 1'b1;
      end else begin
         ovs_d_reg <= ovs_d_next;
         static_cnt_reg <= static_cnt_next;
         codec_active_reg <= codec_active_next;
         light_d_reg <= light_d_next;
         rx_cnt_reg <= rx_cnt_next;
         tx_cnt_reg <= tx_cnt_next;
         ir_rx_reg <= ir_rx_next;
         mon_d_reg <= mon_d_next;
         route_d_reg <= route_d_next;
         ctrl_reg <= ctrl_next;
         ser_state_reg <= ser_state_next;
         ser_sh_reg <= ser_sh_next;
         ser_bit_reg <= ser_bit_next;
         ser_tick_reg <= ser_tick_next;
         readdata <= readdata_next;
         waitrequest <= waitrequest_next;
         led_sink_output <= led_next.out;
         led_sink_oe <= led_next.oe;
         optical_rx_output <= opt_rx_next;
         wired_tx_first_output <= tx1_next.out;
         wired_tx_first_oe <= tx1_next.oe;
         wired_tx_second_output <= tx2_next.out;
         wired_tx_second_oe <= tx2_next.oe;
         charge_pump_en <= pump_next;
         wired_rx_first_output <= rx1_next;
         shared_rx_output <= shared_rx_next;
         idle_line_activity_n <= act_n_next;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_light_hit;
      codec_active_reg && light_rise;
   endsequence

   property p_rx_stretch;
      s_light_hit |=> !ir_rx_reg ##1 !optical_rx_output;
   endproperty
   a_rx_stretch: assert property (p_rx_stretch) else $error("light pulse not stretched");

   property p_bypass_rx;
      !codec_active_reg && light |=> !ir_rx_reg;
   endproperty
   a_bypass_rx: assert property (p_bypass_rx) else $error("bypass receive not low");

   property p_tx_pulse;
      codec_active_reg && ir_en && tx_cnt_reg > irc_pkg::TX_ON_ABOVE |=> led_sink_oe;
   endproperty
   a_tx_pulse: assert property (p_tx_pulse) else $error("LED pulse missing");

   property p_bypass_led;
      !codec_active_reg && ir_en && tx_src |=> led_sink_oe;
   endproperty
   a_bypass_led: assert property (p_bypass_led) else $error("bypass LED off");

   property p_led_off_wired;
      p.infrared_route_select && !p.separate_variant |=> !led_sink_oe;
   endproperty
   a_led_off_wired: assert property (p_led_off_wired) else $error("LED on in wired route");

   property p_wired_hiz;
      !drive_en |=> !wired_tx_first_oe && !wired_tx_second_oe && !charge_pump_en;
   endproperty
   a_wired_hiz: assert property (p_wired_hiz) else $error("wired output driven");

   property p_act_set;
      edge_seen |=> !idle_line_activity_n;
   endproperty
   a_act_set: assert property (p_act_set) else $error("edge not flagged");

   property p_act_clear;
      route_chg && !edge_seen |=> idle_line_activity_n;
   endproperty
   a_act_clear: assert property (p_act_clear) else $error("flag not cleared");

   property p_act_hold;
      !idle_line_activity_n && !route_chg |=> !idle_line_activity_n;
   endproperty
   a_act_hold: assert property (p_act_hold) else $error("flag released early");

   property p_opt_sd;
      !p.optical_shutdown_n |=> optical_rx_output;
   endproperty
   a_opt_sd: assert property (p_opt_sd) else $error("receiver not high in shutdown");

   property p_rx_invert;
      1'b1 |=> wired_rx_first_output == !$past(p.wired_rx_first_input);
   endproperty
   a_rx_invert: assert property (p_rx_invert) else $error("wired receiver not inverting");
endmodule

// File: sim/uart_side_model.sv
// Far-side UART model: 16x oversample clock source and frame sender
module uart_side_model #(
   parameter int P = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control from the bench
   input wire logic run,
   input wire logic hold_low,
   input wire logic send,
   input wire logic [7:0] byte_in,
   // Lines toward the block
   output logic oversample_clock,
   output logic shared_tx_input,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ns;
   int div;
   int ticks;
   logic [9:0] frame;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div <= 0;
         ticks <= 0;
         frame <= '1;
         busy <= 1'b0;
      end else begin
         div <= run ? (div + 1) % P : 0;
         if (send && !busy) begin
            frame <= {1'b1, byte_in, 1'b0};
            ticks <= 160;
            busy <= 1'b1;
         end else if (run && div == P - 1 && busy) begin
            ticks <= ticks - 1;
            if (ticks % 16 == 1) frame <= {1'b1, frame[9:1]};
            busy <= ticks != 1;
         end
      end
   end

   assign oversample_clock = run && div >= P / 2;
   // Idle line is high, as a UART leaves it
   assign shared_tx_input = hold_low ? 1'b0 : frame[0];
endmodule

// File: sim/ir_pulse_codec_mode_mux_bench.sv
// Self-checking bench of the infrared codec and mode mux
module ir_pulse_codec_mode_mux_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int P = 4;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata, rd;
   logic waitrequest;
   logic light = 1'b0, tx1 = 1'b0, rx1 = 1'b0, rx2 = 1'b0, route = 1'b0;
   logic wsd = 1'b1, osd = 1'b1, otx = 1'b0, sep = 1'b0;
   logic run = 1'b0, hold_low = 1'b0, send = 1'b0, led_prev = 1'b0;
   logic [7:0] byte_in = 8'h00;
   logic osc, stx, mbusy, led_out, led_oe, orx, w1, w1oe, w2, w2oe, pump, wr1, srx, act_n;
   irc_pkg::pins_in_t pins;
   int error_cnt = 0;
   int total_checks = 0;
   int pulses = 0, hi_cyc = 0, rx_low = 0, b, h, n, m;

   assign pins = '{oversample_clock: osc, photodiode_input: light, shared_tx_input: stx,
      wired_tx_first_input: tx1, wired_rx_first_input: rx1, wired_rx_second_input: rx2,
      infrared_route_select: route, wired_shutdown_n: wsd, optical_shutdown_n: osd,
      optical_tx_input: otx, separate_variant: sep};

   always #25 clk = ~clk;

   uart_side_model #(.P(P)) i_uart (.clk(clk), .rst_n(rst_n), .run(run),
      .hold_low(hold_low), .send(send), .byte_in(byte_in), .oversample_clock(osc),
      .shared_tx_input(stx), .busy(mbusy));

   ir_pulse_codec_mode_mux i_dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
      .write(write), .byteenable(4'hf), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .pins_in(pins), .led_sink_output(led_out),
      .led_sink_oe(led_oe), .optical_rx_output(orx), .wired_tx_first_output(w1),
      .wired_tx_first_oe(w1oe), .wired_tx_second_output(w2), .wired_tx_second_oe(w2oe),
      .charge_pump_en(pump), .wired_rx_first_output(wr1), .shared_rx_output(srx),
      .idle_line_activity_n(act_n));

   // LED pulses, lit cycles and stretched receive cycles
   always @(posedge clk) begin
      led_prev <= led_oe;
      if (led_oe === 1'b1 && led_prev === 1'b0) pulses++;
      if (led_oe === 1'b1) hi_cyc++;
      if (srx === 1'b0) rx_low++;
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Holds the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      do begin
         @(posedge clk);
         k++;
      end while (waitrequest !== 1'b0 && k < 40);
      rd = readdata;
      check(waitrequest, 1'b0);
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic send_byte(input logic [7:0] v);
      int k;
      k = 0;
      byte_in <= v;
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      do begin
         @(posedge clk);
         k++;
      end while (mbusy !== 1'b0 && k < 3000);
      cyc(12);
   endtask

   task automatic final_report;
      $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      cyc(3);
      rst_n <= 1'b1;
      cyc(6);
      bus(0, irc_pkg::ADDR_CTRL, 0);
      check(rd, 32'h0);
      bus(0, irc_pkg::ADDR_STATUS, 0);
      check(rd, 32'h0000000c);
      bus(0, 4'hc, 0);
      check(rd, 32'h0);
      bus(1, irc_pkg::ADDR_STATUS, 32'hff);
      bus(1, irc_pkg::ADDR_CTRL, 32'h3);
      bus(0, irc_pkg::ADDR_CTRL, 0);
      check(rd, 32'h3);
      bus(1, irc_pkg::ADDR_CTRL, 32'h0);
      bus(0, irc_pkg::ADDR_TXDATA, 0);
      check(rd, 32'h0);
      $display("test registers done");
      check(led_oe, 1'b1);
      hold_low <= 1'b1;
      cyc(6);
      check(led_oe, 1'b0);
      hold_low <= 1'b0;
      b = rx_low;
      light <= 1'b1;
      cyc(3);
      light <= 1'b0;
      cyc(8);
      check((rx_low - b) inside {[1:4]}, 1'b1);
      $display("test bypass done");
      sep <= 1'b1;
      otx <= 1'b1;
      hold_low <= 1'b1;
      cyc(6);
      check(led_oe, 1'b1);
      otx <= 1'b0;
      hold_low <= 1'b0;
      osd <= 1'b0;
      light <= 1'b1;
      cyc(7);
      check({led_oe, orx}, 2'b01);
      osd <= 1'b1;
      cyc(7);
      check(orx, 1'b0);
      light <= 1'b0;
      sep <= 1'b0;
      $display("test separate done");
      for (int i = 0; i < 4; i++) begin
         route <= i[1];
         wsd <= i[0];
         rx1 <= i[0];
         rx2 <= i[1] ^ i[0];
         tx1 <= 1'b1;
         cyc(6);
         check({w1oe, w2oe, pump}, {3{i[1] & i[0]}});
         check({led_oe, wr1}, {!i[1], !i[0]});
         if (i[1]) check(srx, !(i[1] ^ i[0]));
         if (i == 3) check({w1, w2, led_out}, 3'b000);
      end
      $display("test wired done");
      route <= 1'b0;
      cyc(6);
      check(act_n, 1'b1);
      light <= 1'b1;
      cyc(2);
      light <= 1'b0;
      cyc(6);
      check(act_n, 1'b1);
      rx2 <= 1'b1;
      cyc(6);
      check(act_n, 1'b0);
      rx2 <= 1'b0;
      cyc(6);
      bus(0, irc_pkg::ADDR_STATUS, 0);
      check({act_n, rd[irc_pkg::ST_ACT_BIT]}, 2'b00);
      route <= 1'b1;
      cyc(6);
      check(act_n, 1'b1);
      rx2 <= 1'b1;
      cyc(6);
      check(act_n, 1'b1);
      light <= 1'b1;
      cyc(2);
      light <= 1'b0;
      cyc(6);
      check(act_n, 1'b0);
      route <= 1'b0;
      cyc(6);
      check(act_n, 1'b1);
      $display("test activity done");
      run <= 1'b1;
      cyc(40);
      bus(0, irc_pkg::ADDR_STATUS, 0);
      check(rd[irc_pkg::ST_CODEC_BIT], 1'b1);
      b = pulses;
      h = hi_cyc;
      send_byte(8'h00);
      check(pulses - b, 9);
      check(hi_cyc - h, 27 * P);
      b = pulses;
      send_byte(8'hf0);
      check(pulses - b, 5);
      b = rx_low;
      light <= 1'b1;
      cyc(2);
      light <= 1'b0;
      cyc(90);
      check((rx_low - b) inside {[15 * P:16 * P + 1]}, 1'b1);
      run <= 1'b0;
      cyc(420);
      bus(0, irc_pkg::ADDR_STATUS, 0);
      check({rd[irc_pkg::ST_CODEC_BIT], led_oe}, 2'b01);
      $display("test codec done");
      bus(1, irc_pkg::ADDR_CTRL, 32'h1);
      n = 0;
      do begin
         bus(1, irc_pkg::ADDR_TXDATA, 32'hf0);
         n++;
         bus(0, irc_pkg::ADDR_STATUS, 0);
      end while (rd[irc_pkg::ST_FULL_BIT] !== 1'b1 && n < 12);
      check(n, irc_pkg::FIFO_DEPTH + 1);
      b = pulses;
      run <= 1'b1;
      m = 0;
      do begin
         cyc(100);
         bus(0, irc_pkg::ADDR_STATUS, 0);
         m++;
      end while (rd[5:3] !== 3'b001 && m < 100);
      check(rd[5:3], 3'b001);
      cyc(10);
      check(pulses - b, 4 * n);
      bus(1, irc_pkg::ADDR_CTRL, 32'h0);
      $display("test fifo done");
      final_report();
   end

   // Whole run needs well under 20000 cycles
   initial begin
      cyc(60000);
      error_cnt++;
      $display("MISMATCH t=%0t watchdog got=%h exp=%h", $time, 1'b1, 1'b0);
      final_report();
   end
endmodule
